// file: shared/linear_array_if.sv
// interface joining the controller and the sensor array end
`timescale 1ns/100ps
interface linear_array_if
  import linear_array_pkg::*;
();
  logic start_pulse;
  logic link_clock;
  logic [pixel_width-1:0] pixel_voltage_out;
  // enable low stands for the released, high-impedance output of the array
  logic pixel_out_en;

  modport array_end (input start_pulse, input link_clock, output pixel_voltage_out,
    output pixel_out_en);
  modport controller_end (output start_pulse, output link_clock, input pixel_voltage_out,
    input pixel_out_en);
endinterface : linear_array_if

// file: shared/linear_array_pkg.sv
// constants and types shared by the linear array sensor model and its controller
// Functional notes
// - start captured: hold pixel 1, then reset integrator; the model closes both switches in the same mclk cycle
// - next period: release reset, resample, advance pixel
// - after pixel 64, output high-impedance past edge n+1
// - new start allowed on clock n+1
// - controller keeps start spacing at most 100 ms
// - integration time equals interval between pixel reads
// - integration time at least period times pixels
// - power-up: one start then n+1 flush clocks
// - controller parks clock low while idle
// - controller clock never faster than 5 MHz
// - pixel value held for whole clock period
// - keep clock rate constant during readout; a full fifo stretches a low half of the controller clock
// - start pulse low before next rising edge
package linear_array_pkg;
  // ----------------------------------------------------------------
  // array geometry and timing
  // ----------------------------------------------------------------
  localparam int pixel_count = 64;
  localparam int pixel_width = 8;
  localparam int index_width = 7;
  localparam int mclk_period_ns = 10;
  localparam int max_link_khz = 5000;
  localparam int min_link_period_ns = 1000000 / max_link_khz;
  // half period of the link clock in mclk cycles, rounded up so the link never exceeds 5 MHz
  localparam int link_half_cycles = (min_link_period_ns / 2 + mclk_period_ns - 1) / mclk_period_ns;
  localparam int max_start_spacing_ms = 100;
  localparam int max_start_spacing_cycles = max_start_spacing_ms * 100000;
  localparam logic [index_width-1:0] last_pixel = 7'h40;
  localparam logic [index_width-1:0] idle_index = 7'h00;

  typedef enum logic [1:0] {ctl_flush, ctl_idle, ctl_high, ctl_low} ctl_state_t;
endpackage : linear_array_pkg

// file: verif/linear_array_sva.sv
// checker of the link between the array end and its controller
`timescale 1ns/100ps
module linear_array_sva
  import linear_array_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic start_pulse,
  input wire logic link_clock,
  input wire logic [pixel_width-1:0] pixel_voltage_out,
  input wire logic pixel_out_en
);
  // ----------------------------------------------------------------
  // link edge counter
  // ----------------------------------------------------------------
  logic link_prev;
  logic link_rise;
  logic [index_width-1:0] edge_count;
  logic [index_width-1:0] next_edge_count;
  assign link_rise = link_clock && !link_prev;
  // saturates rather than wraps, so a stray edge long after a scan still shows
  always_comb begin
    next_edge_count = edge_count;
    if (link_rise && start_pulse) begin
      next_edge_count = 7'h01;
    end else if (link_rise && edge_count != 7'h7f) begin
      next_edge_count = edge_count + 7'h01;
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      link_prev <= 1'b0;
      edge_count <= 7'h00;
    end else begin
      link_prev <= link_clock;
      edge_count <= next_edge_count;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence s_start_edge;
    link_rise && start_pulse;
  endsequence
  sequence s_last_edge;
    link_rise && !start_pulse && edge_count == last_pixel;
  endsequence
  chk_out_on_start: assert property (s_start_edge |-> ##[1:6] pixel_out_en)
    else $error("output not driven after start");
  chk_hiz_after_last: assert property (s_last_edge |-> ##[1:6] !pixel_out_en)
    else $error("output still driven after edge 65");
  chk_restart_spacing: assert property (s_start_edge |-> edge_count == 7'h00 ||
    edge_count >= last_pixel) else $error("start issued inside a scan");
  chk_start_drop: assert property (s_start_edge |-> ##[1:19] !start_pulse)
    else $error("start held past next edge");
  chk_parked_clock: assert property ((edge_count > last_pixel && !start_pulse) |->
    !link_rise) else $error("link clock ran while idle");
  chk_value_stands: assert property ($fell(link_clock) |=>
    $stable(pixel_voltage_out)[*5]) else $error("pixel value moved within period");
  chk_high_phase: assert property ($rose(link_clock) |=> link_clock[*8])
    else $error("link high phase too short");
  chk_low_phase: assert property ($fell(link_clock) |=> !link_clock[*8])
    else $error("link low phase too short");
  chk_enable_first: assert property ($rose(pixel_out_en) |-> edge_count == 7'h01)
    else $error("output enabled away from pixel 1");
endmodule : linear_array_sva

// file: verif/testbench.sv
// self-checking bench joining the array end and its controller
`timescale 1ns/100ps
module testbench
  import linear_array_pkg::*;
;
  localparam int spacing = 3000;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [pixel_width-1:0] light_level = 8'h00;
  logic scan_request = 1'b0;
  logic sample_ready = 1'b0;
  logic irs, shs, scan_busy, ready_for_scan, sample_valid;
  logic [index_width-1:0] active_pixel;
  logic [index_width+pixel_width-1:0] sample_data;
  int bad_count = 0;
  int n_compared = 0;
  // ----------------------------------------------------------------
  // structure
  // ----------------------------------------------------------------
  always #5 mclk = ~mclk;
  linear_array_if u_linear_array_if();
  linear_array_sensor #(.pixels(pixel_count)) u_linear_array_sensor (.mclk(mclk),
    .reset_n(reset_n), .link(u_linear_array_if.array_end), .light_level(light_level),
    .integrator_reset_switch(irs), .sample_hold_switch(shs), .active_pixel(active_pixel));
  linear_array_controller #(.spacing_cycles(spacing)) u_linear_array_controller (
    .mclk(mclk), .link(u_linear_array_if.controller_end), .reset_n(reset_n),
    .scan_request(scan_request), .scan_busy(scan_busy), .ready_for_scan(ready_for_scan),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_data(sample_data));
  linear_array_sva u_linear_array_sva (.mclk(mclk), .reset_n(reset_n),
    .start_pulse(u_linear_array_if.start_pulse), .link_clock(u_linear_array_if.link_clock),
    .pixel_voltage_out(u_linear_array_if.pixel_voltage_out),
    .pixel_out_en(u_linear_array_if.pixel_out_en));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check_val(input string what, input logic [14:0] exp, input logic [14:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  // bounded wait, so a controller that never idles is reported instead of hanging
  task automatic wait_ready;
    int t;
    t = 0;
    do begin
      @(posedge mclk);
      t++;
    end while (ready_for_scan !== 1'b1 && t < 20000);
    check_val("ready_for_scan", 15'h0001, {14'h0000, ready_for_scan});
  endtask : wait_ready
  task automatic start_scan;
    @(posedge mclk);
    scan_request <= 1'b1;
    @(posedge mclk);
    scan_request <= 1'b0;
  endtask : start_scan
  // stall holds ready low long enough for the fifo to fill and the link to stretch
  task automatic read_scan(input logic [7:0] level, input bit stall);
    int k;
    int t;
    bit saw_switch;
    k = 1;
    t = 0;
    saw_switch = 1'b0;
    sample_ready <= !stall;
    while (k <= pixel_count && t < 20000) begin
      @(posedge mclk);
      t++;
      // both switches close together in the high half of each active period
      if (irs === 1'b1 && shs === 1'b1) begin
        saw_switch = 1'b1;
      end
      if (stall && t == 600) begin
        check_val("stalled valid", 15'h0001, {14'h0000, sample_valid});
        check_val("stalled busy", 15'h0001, {14'h0000, scan_busy});
        sample_ready <= 1'b1;
      end
      if (sample_valid === 1'b1 && sample_ready === 1'b1) begin
        check_val("sample", {k[6:0], level}, sample_data);
        k++;
      end
    end
    check_val("sample count", 15'h0041, 15'(k));
    check_val("switch pulses", 15'h0001, {14'h0000, saw_switch});
  endtask : read_scan
  // ----------------------------------------------------------------
  // sequence of scans
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    wait_ready();
    check_val("flush samples", 15'h0000, {14'h0000, sample_valid});
    light_level <= 8'h5a;
    start_scan();
    repeat (50) @(posedge mclk);
    start_scan();
    read_scan(8'h5a, 1'b0);
    wait_ready();
    check_val("active pixel", {8'h00, idle_index}, {8'h00, active_pixel});
    check_val("switches idle", 15'h0000, {13'h0000, irs, shs});
    repeat (200) @(posedge mclk);
    check_val("extra samples", 15'h0000, {14'h0000, sample_valid});
    light_level <= 8'h3c;
    start_scan();
    read_scan(8'h3c, 1'b1);
    wait_ready();
    light_level <= 8'hc3;
    read_scan(8'hc3, 1'b0);
    wrap_up();
  end
  // watchdog well beyond the few thousand cycles the scans need
  initial begin
    #600000;
    bad_count++;
    wrap_up();
  end
endmodule : testbench

// file: verilog/linear_array_controller.sv
// controller that drives start and link clock and collects tagged pixels via a fifo
`timescale 1ns/100ps
module linear_array_controller
  import linear_array_pkg::*;
#(
  parameter int pixels = pixel_count,
  parameter int half_cycles = link_half_cycles,
  parameter int spacing_cycles = max_start_spacing_cycles,
  parameter int fifo_depth = 8
) (
  input wire logic mclk,
  linear_array_if.controller_end link,
  input wire logic reset_n,
  input wire logic scan_request,
  output logic scan_busy,
  output logic ready_for_scan,
  output logic sample_valid,
  input wire logic sample_ready,
  output logic [index_width+pixel_width-1:0] sample_data
);
  localparam int sw = index_width + pixel_width;
  ctl_state_t state, next_state;
  logic [15:0] half_cnt, next_half_cnt;
  logic [index_width:0] clk_cnt, next_clk_cnt;
  logic [31:0] gap_cnt, next_gap_cnt;
  logic next_start, next_lclk, flushed, next_flushed;
  logic [pixel_width-1:0] pix_s1, pix_s2;
  logic en_s1, en_s2;
  logic f_in_valid, f_in_ready, f_out_valid;
  logic [sw-1:0] f_out_data;
  logic next_sample_valid;
  logic [sw-1:0] next_sample_data;
  logic start_now;

  // ----------------------------------------------------------------
  // operation
  // ----------------------------------------------------------------
  // after reset one flush scan clears whatever the array held at power-up;
  // its pixels are never queued, so the reader only sees settled data.
  // each link period is a low half then a high half of half_cycles mclk.
  // the array moves on at the rising edge, so pixel k is read late in the
  // low half that follows edge k, while its value still stands, tagged k.
  // edge n+1 ends every scan; the array releases its output there.
  // a scan starts on request or when the spacing counter runs out,
  // whichever comes first, which bounds integration time from above.
  // a full fifo holds the sequencer in a low half: the link clock
  // stretches and that period integrates longer, but no pixel is lost.

  // ----------------------------------------------------------------
  // half-period test shared by both halves of the link clock, pixel-range test used in the low half
  // ----------------------------------------------------------------
  // true in the last mclk cycle of either half period
  function automatic logic half_done(input logic [15:0] cnt);
    half_done = (cnt == 16'(half_cycles - 1));
  endfunction : half_done

  // true while the count names a real pixel, 1 through pixels
  function automatic logic is_pixel(input logic [index_width:0] cnt);
    is_pixel = (cnt >= 8'h01) && (cnt <= 8'(pixels));
  endfunction : is_pixel

  // ----------------------------------------------------------------
  // pixel input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pix_s1 <= '0;
      pix_s2 <= '0;
      en_s1 <= 1'b0;
      en_s2 <= 1'b0;
    end else begin
      pix_s1 <= link.pixel_voltage_out;
      pix_s2 <= pix_s1;
      en_s1 <= link.pixel_out_en;
      en_s2 <= en_s1;
    end
  end

  // ----------------------------------------------------------------
  // scan sequencer: flush after reset, then scans on request
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_half_cnt = half_cnt;
    next_clk_cnt = clk_cnt;
    next_start = link.start_pulse;
    next_lclk = link.link_clock;
    next_flushed = flushed;
    f_in_valid = 1'b0;
    case (state)
      ctl_idle: begin
        next_lclk = 1'b0;
        // the spacing counter forces a scan before the charge limit
        if (start_now) begin
          next_start = 1'b1;
          next_clk_cnt = '0;
          next_half_cnt = 16'h0;
          next_state = ctl_low;
        end
      end
      ctl_flush, ctl_low: begin
        // fixed half period keeps the rate within 5 MHz, constant unless a full fifo stalls this low half
        if (half_done(half_cnt)) begin
          // pixel k still stands here; the edge that moves the array on comes next
          if (is_pixel(clk_cnt) && flushed) begin
            f_in_valid = en_s2;
          end
          next_half_cnt = 16'h0;
          next_lclk = 1'b1;
          next_state = ctl_high;
        end else begin
          next_half_cnt = half_cnt + 16'h1;
        end
      end
      ctl_high: begin
        // a full pixel period lets the array output settle before capture
        if (half_done(half_cnt)) begin
          next_half_cnt = 16'h0;
          next_lclk = 1'b0;
          next_start = 1'b0;
          next_clk_cnt = clk_cnt + 8'h01;
          // no start before edge n+1, so integration spans a full scan
          if (clk_cnt == 8'(pixels)) begin
            next_flushed = 1'b1;
            next_state = ctl_idle;
          end else begin
            next_state = ctl_low;
          end
        end else begin
          next_half_cnt = half_cnt + 16'h1;
        end
      end
      default: next_state = ctl_idle;
    endcase
  end

  // a full fifo stalls the sequencer so no pixel is dropped
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ctl_flush;
      half_cnt <= 16'h0;
      clk_cnt <= '0;
      flushed <= 1'b0;
      link.start_pulse <= 1'b1;
      link.link_clock <= 1'b0;
    end else if (!(f_in_valid && !f_in_ready)) begin
      state <= next_state;
      half_cnt <= next_half_cnt;
      clk_cnt <= next_clk_cnt;
      flushed <= next_flushed;
      link.start_pulse <= next_start;
      link.link_clock <= next_lclk;
    end
  end

  // ----------------------------------------------------------------
  // start spacing counter
  // ----------------------------------------------------------------
  // a start in idle, asked for or forced by an empty spacing count
  assign start_now = (state == ctl_idle) && (scan_request || gap_cnt == '0);

  // counts down from each start; it runs on through fifo stalls so the
  // real time between starts stays bounded by the charge limit
  always_comb begin
    next_gap_cnt = (gap_cnt != '0) ? gap_cnt - 32'h1 : gap_cnt;
    if (start_now) begin
      next_gap_cnt = 32'(spacing_cycles);
    end
  end

  // the flush start at reset opens the first spacing interval
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      gap_cnt <= 32'(spacing_cycles);
    end else begin
      gap_cnt <= next_gap_cnt;
    end
  end

  // ----------------------------------------------------------------
  // pixel queue
  // ----------------------------------------------------------------
  // eight entries ride out a slow reader before the link must stretch
  pixel_fifo #(.width(sw), .depth(fifo_depth)) fifo_i (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data({clk_cnt[index_width-1:0], pix_s2}),
    .out_valid(f_out_valid),
    .out_ready(!sample_valid || sample_ready),
    .out_data(f_out_data)
  );

  // ----------------------------------------------------------------
  // output register stage
  // ----------------------------------------------------------------
  // takes a new word whenever it is empty or being read
  always_comb begin
    next_sample_valid = sample_valid;
    next_sample_data = sample_data;
    if (!sample_valid || sample_ready) begin
      next_sample_valid = f_out_valid;
      next_sample_data = f_out_valid ? f_out_data : sample_data;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sample_valid <= 1'b0;
      sample_data <= '0;
      scan_busy <= 1'b1;
      ready_for_scan <= 1'b0;
    end else begin
      sample_valid <= next_sample_valid;
      sample_data <= next_sample_data;
      scan_busy <= (next_state != ctl_idle);
      ready_for_scan <= (next_state == ctl_idle) && next_flushed;
    end
  end
endmodule : linear_array_controller

// file: verilog/linear_array_sensor.sv
// digital model of the 64-pixel array readout sequencer, clocked by mclk
`timescale 1ns/100ps
module linear_array_sensor
  import linear_array_pkg::*;
#(
  parameter int pixels = pixel_count
) (
  input wire logic mclk,
  input wire logic reset_n,
  linear_array_if.array_end link,
  input wire logic [pixel_width-1:0] light_level,
  output logic integrator_reset_switch,
  output logic sample_hold_switch,
  output logic [index_width-1:0] active_pixel
);
  logic [2:0] clk_sync, start_sync;
  logic [index_width-1:0] next_active_pixel;
  logic next_reset_sw, next_hold_sw, next_out_en;
  logic [pixel_width-1:0] next_out;
  logic rise;

  // ----------------------------------------------------------------
  // pin synchronisers; only stage two onwards feeds logic
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      clk_sync <= '0;
      start_sync <= '0;
    end else begin
      clk_sync <= {clk_sync[1:0], link.link_clock};
      start_sync <= {start_sync[1:0], link.start_pulse};
    end
  end
  assign rise = clk_sync[1] && !clk_sync[2];

  // ----------------------------------------------------------------
  // pixel sequencing on each rising link clock
  // ----------------------------------------------------------------
  always_comb begin
    next_active_pixel = active_pixel;
    next_reset_sw = integrator_reset_switch;
    next_hold_sw = sample_hold_switch;
    next_out_en = link.pixel_out_en;
    next_out = link.pixel_voltage_out;
    if (rise) begin
      if (start_sync[1]) begin
        next_active_pixel = 7'h01;
        next_hold_sw = 1'b1;
        next_reset_sw = 1'b1;
        next_out_en = 1'b1;
        next_out = light_level;
      end else if (active_pixel != idle_index && active_pixel < index_width'(pixels)) begin
        next_active_pixel = active_pixel + 7'h01;
        next_reset_sw = 1'b1;
        next_hold_sw = 1'b1;
        next_out = light_level;
      end else begin
        next_active_pixel = idle_index;
        next_reset_sw = 1'b0;
        next_hold_sw = 1'b0;
        next_out_en = 1'b0;
        next_out = '0;
      end
    end else if (!clk_sync[1]) begin
      // the second half of each period releases the switches
      next_reset_sw = 1'b0;
      next_hold_sw = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      active_pixel <= idle_index;
      integrator_reset_switch <= 1'b0;
      sample_hold_switch <= 1'b0;
      link.pixel_out_en <= 1'b0;
      link.pixel_voltage_out <= '0;
    end else begin
      active_pixel <= next_active_pixel;
      integrator_reset_switch <= next_reset_sw;
      sample_hold_switch <= next_hold_sw;
      link.pixel_out_en <= next_out_en;
      link.pixel_voltage_out <= next_out;
    end
  end
endmodule : linear_array_sensor

// file: verilog/pixel_fifo.sv
// parameterised flip-flop fifo with valid and ready on both sides
`timescale 1ns/100ps
module pixel_fifo #(
  parameter int width = 15,
  parameter int depth = 8
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [width-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [width-1:0] out_data
);
  localparam int aw = $clog2(depth);
  logic [width-1:0] mem [depth];
  logic [aw-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [aw:0] fill, next_fill;
  logic push, pop;

  // ----------------------------------------------------------------
  // pointer arithmetic
  // ----------------------------------------------------------------
  function automatic logic [aw-1:0] bump(input logic [aw-1:0] p);
    bump = (p == aw'(depth - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  assign in_ready = (fill != (aw+1)'(depth));
  assign out_valid = (fill != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // next pointers and fill level
  always_comb begin
    next_wr_ptr = push ? bump(wr_ptr) : wr_ptr;
    next_rd_ptr = pop ? bump(rd_ptr) : rd_ptr;
    next_fill = fill + (aw+1)'(push) - (aw+1)'(pop);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      fill <= next_fill;
    end
  end

  // storage has no reset; only written slots are ever read
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : pixel_fifo
